// [dv/gs_host_model.sv]
// host side of the serial chain: drives shift clock, data and latch pins
// assumes the latch filters its pins on mclk, so each level is held 5 mclk
`timescale 1ns/10ps
`default_nettype none
module gs_host_model
    import gs_latch_pkg::*;
(
    input wire logic mclk_i,
    input wire logic serial_out_pin_i,
    output var pins_t pins_o
);
    localparam int HOLD = 5;

    initial begin
        pins_o = PINS_RESET;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    // msb first; the chain output is taken before each rise, so 288 bits empty it
    task automatic frame(input logic [GS_WIDTH-1:0] din, input int n, input bit do_lat,
            output logic [GS_WIDTH-1:0] dout);
        dout = GS_RESET;
        for (int i = 0; i < n; i++) begin
            pins_o.sdi = din[n-1-i];
            wait_clk(HOLD);
            dout[GS_WIDTH-1-i] = serial_out_pin_i;
            pins_o.sck = 1'b1;
            wait_clk(HOLD);
            pins_o.sck = 1'b0;
        end
        // data line flips after the frame so a stale bit is never mistaken for a hold
        pins_o.sdi = ~pins_o.sdi;
        if (do_lat) begin
            wait_clk(HOLD);
            pins_o.lat = 1'b1;
            wait_clk(HOLD);
            pins_o.lat = 1'b0;
        end
        wait_clk(2 * HOLD);
    endtask
endmodule
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the grayscale data latch
// assumes the host model paces the pins slow enough for the pin filter
`timescale 1ns/10ps
`default_nettype none
module testbench
    import gs_latch_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    pins_t pins;
    logic serial_out_pin;
    gs_group_t blue;
    gs_group_t red;
    logic [GS_WIDTH-1:0] common;
    logic [GS_WIDTH-1:0] pat;
    logic [GS_WIDTH-1:0] dout;
    logic [FBC_WIDTH-1:0] fbc = {41{5'h15}};
    logic [GS_WIDTH-1:0] status_info_data = {36{8'h5B}};
    logic fbc_load;
    logic err_clr;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int err_pulses = 0;
    int fbc_pulses = 0;

    led_grayscale_data_latch i_led_grayscale_data_latch (
        .mclk_i(mclk), .rst_i(rst), .sck_i(pins.sck), .sdi_i(pins.sdi), .lat_i(pins.lat),
        .fbc_data_i(fbc), .status_info_data_i(status_info_data), .serial_out_pin_o(serial_out_pin),
        .blue_group_output_o(blue), .red_group_output_o(red), .common_word_o(common),
        .fbc_load_o(fbc_load), .err_clear_o(err_clr));

    gs_host_model i_gs_host_model (.mclk_i(mclk), .serial_out_pin_i(serial_out_pin), .pins_o(pins));

    always #5 mclk = ~mclk;

    task automatic results();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // pulses are counted so their one-cycle width cannot slip past a late look
    always @(posedge mclk) begin
        cycles++;
        if (!rst) begin
            err_pulses += int'(err_clr === 1'b1);
            fbc_pulses += int'(fbc_load === 1'b1);
        end
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end

    task automatic chk(input string name, input logic [GS_WIDTH-1:0] exp,
            input logic [GS_WIDTH-1:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    task automatic groups(input logic [GS_WIDTH-1:0] w);
        for (int ch = 0; ch < CHANNELS; ch++) begin
            chk("blue", GS_WIDTH'(w[ch*36+24 +: 12]), GS_WIDTH'(blue[ch]));
            chk("red", GS_WIDTH'(w[ch*36 +: 12]), GS_WIDTH'(red[ch]));
        end
    endtask

    task automatic cmd(input logic [11:0] c);
        i_gs_host_model.frame(GS_WIDTH'(c), 12, 1'b1, dout);
    endtask

    initial begin
        for (int k = 0; k < 24; k++) begin
            pat[k*12 +: 12] = 12'(k * 273 + 7);
        end
        repeat (8) @(posedge mclk);
        #1;
        rst = 1'b0;
        groups('0);
        chk("common_rst", GS_RESET, common);
        i_gs_host_model.frame(pat, 288, 1'b1, dout);
        groups(pat);
        chk("fbc_after_write", GS_WIDTH'(fbc), common);
        cmd(CMD_GS_READ);
        chk("gs_read", pat, common);
        chk("sdo_first", GS_WIDTH'(pat[287]), GS_WIDTH'(serial_out_pin));
        i_gs_host_model.frame(~pat, 288, 1'b1, dout);
        chk("gs_shift_out", pat, dout);
        groups(~pat);
        cmd(CMD_FBC_READ);
        chk("fbc_read", GS_WIDTH'(fbc), common);
        cmd(CMD_SID_READ);
        chk("sid_read", status_info_data, common);
        cmd(CMD_ERR_CLEAR);
        chk("err_clear_read", status_info_data, common);
        chk("err_pulses", GS_WIDTH'(1), GS_WIDTH'(err_pulses));
        i_gs_host_model.frame(GS_WIDTH'(20'hABCDE), 20, 1'b1, dout);
        chk("fbc_pulses", GS_WIDTH'(1), GS_WIDTH'(fbc_pulses));
        cmd(12'h123);
        chk("null_cmd_pulses", GS_WIDTH'(2), GS_WIDTH'(fbc_pulses));
        chk("null_cmd_word", GS_WIDTH'(12'h123), GS_WIDTH'(common[11:0]));
        groups(~pat);
        cmd(CMD_GLOBAL_RESET);
        groups('0);
        chk("common_greset", GS_RESET, common);
        results();
    end
endmodule
`default_nettype wire

// [logic/gs_latch_pkg.sv]
// constants, types and helpers for the grayscale data latch
// assumes one 100 MHz clock and a serial host on asynchronous pins
`default_nettype none
package gs_latch_pkg;
    localparam int GS_WIDTH = 288;
    localparam int FBC_WIDTH = 205;
    localparam int SLOT_W = 12;
    localparam int CHANNELS = 8;
    localparam int STRIDE = 36;
    localparam int BLUE_LSB = 24;
    localparam int RSV_LSB = 12;
    localparam int RED_LSB = 0;
    localparam int GS_REG_OFFSET = 0;
    localparam logic [8:0] GS_BITS = 9'h120;
    localparam logic [8:0] CMD_BITS = 9'h00C;
    localparam logic [8:0] CNT_RESET = 9'h000;
    localparam logic [GS_WIDTH-1:0] GS_RESET = {GS_WIDTH{1'b0}};
    localparam logic [11:0] CMD_GS_READ = 12'h5A3;
    localparam logic [11:0] CMD_FBC_READ = 12'h5AC;
    localparam logic [11:0] CMD_SID_READ = 12'hC5A;
    localparam logic [11:0] CMD_ERR_CLEAR = 12'hA53;
    localparam logic [11:0] CMD_GLOBAL_RESET = 12'hA5C;

    typedef struct packed {
        logic sck;
        logic sdi;
        logic lat;
    } pins_t;

    localparam pins_t PINS_RESET = 3'h0;

    typedef logic [CHANNELS-1:0][SLOT_W-1:0] gs_group_t;

    // lsb of a channel slot inside the grayscale word
    function automatic int slot_lsb(input int ch, input int base);
        return ch * STRIDE + base;
    endfunction
endpackage
`default_nettype wire

// [logic/led_grayscale_data_latch.sv]
// grayscale data latch with its serial shift interface and read-back path
// assumes host pins are asynchronous and toggle slower than a few mclk periods
`timescale 1ns/10ps
`default_nettype none
module led_grayscale_data_latch
    import gs_latch_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic sck_i,
    input wire logic sdi_i,
    input wire logic lat_i,
    input wire logic [FBC_WIDTH-1:0] fbc_data_i,
    input wire logic [GS_WIDTH-1:0] status_info_data_i,
    output logic serial_out_pin_o,
    output gs_group_t blue_group_output_o,
    output gs_group_t red_group_output_o,
    output logic [GS_WIDTH-1:0] common_word_o,
    output logic fbc_load_o,
    output logic err_clear_o
);
    pins_t s1_r, s2_r, s3_r, flt_r;
    pins_t s1_nxt, s2_nxt, s3_nxt, flt_nxt;
    pins_t agree;
    logic sck_rise, lat_rise;
    logic [GS_WIDTH-1:0] shift_r, shift_nxt, gs_r, gs_nxt;
    logic [8:0] cnt_r, cnt_nxt;
    logic sdo_r, sdo_nxt, load_r, load_nxt, clr_r, clr_nxt;
    logic [11:0] cmd;

    // pin synchroniser; a level counts once stages two and three agree
    always_comb begin
        s1_nxt = pins_t'({sck_i, sdi_i, lat_i});
        s2_nxt = s1_r;
        s3_nxt = s2_r;
        agree = pins_t'(~(s2_r ^ s3_r));
        flt_nxt = pins_t'((agree & s3_r) | (~agree & flt_r));
        sck_rise = flt_nxt.sck & ~flt_r.sck;
        lat_rise = flt_nxt.lat & ~flt_r.lat;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s1_r <= PINS_RESET;
            s2_r <= PINS_RESET;
            s3_r <= PINS_RESET;
            flt_r <= PINS_RESET;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
            flt_r <= flt_nxt;
        end
    end

    assign cmd = shift_r[SLOT_W-1:0];

    // shift chain and latch; a clock edge takes priority over a latch edge
    always_comb begin
        shift_nxt = shift_r;
        gs_nxt = gs_r;
        cnt_nxt = cnt_r;
        load_nxt = 1'b0;
        clr_nxt = 1'b0;
        if (sck_rise) begin
            shift_nxt = {shift_r[GS_WIDTH-2:0], flt_nxt.sdi};
            cnt_nxt = (cnt_r == GS_BITS) ? cnt_r : cnt_r + 9'h001;
        end else if (lat_rise) begin
            cnt_nxt = CNT_RESET;
            if (cnt_r == GS_BITS) begin
                gs_nxt = shift_r;
                shift_nxt = {{(GS_WIDTH-FBC_WIDTH){1'b0}}, fbc_data_i};
            end else if (cnt_r == CMD_BITS && cmd == CMD_GS_READ) begin
                shift_nxt = gs_r;
            end else if (cnt_r == CMD_BITS && cmd == CMD_FBC_READ) begin
                shift_nxt = {{(GS_WIDTH-FBC_WIDTH){1'b0}}, fbc_data_i};
            end else if (cnt_r == CMD_BITS && cmd == CMD_SID_READ) begin
                shift_nxt = status_info_data_i;
            end else if (cnt_r == CMD_BITS && cmd == CMD_ERR_CLEAR) begin
                shift_nxt = status_info_data_i;
                clr_nxt = 1'b1;
            end else if (cnt_r == CMD_BITS && cmd == CMD_GLOBAL_RESET) begin
                shift_nxt = GS_RESET;
                gs_nxt = GS_RESET;
            end else begin
                // anything else is a configuration write, handed to its owner
                load_nxt = 1'b1;
            end
        end
        sdo_nxt = shift_nxt[GS_WIDTH-1];
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            shift_r <= GS_RESET;
            gs_r <= GS_RESET;
            cnt_r <= CNT_RESET;
            sdo_r <= 1'b0;
            load_r <= 1'b0;
            clr_r <= 1'b0;
        end else begin
            shift_r <= shift_nxt;
            gs_r <= gs_nxt;
            cnt_r <= cnt_nxt;
            sdo_r <= sdo_nxt;
            load_r <= load_nxt;
            clr_r <= clr_nxt;
        end
    end

    // reserved slots go to no group output; they leave gs_r only through a gs read
    always_comb begin
        for (int ch = 0; ch < CHANNELS; ch++) begin
            blue_group_output_o[ch] = gs_r[slot_lsb(ch, BLUE_LSB) +: SLOT_W];
            red_group_output_o[ch] = gs_r[slot_lsb(ch, RED_LSB) +: SLOT_W];
        end
    end

    assign serial_out_pin_o = sdo_r;
    assign common_word_o = shift_r;
    assign fbc_load_o = load_r;
    assign err_clear_o = clr_r;

    logic gs_wr, gs_rd;
    assign gs_wr = lat_rise && !sck_rise && cnt_r == GS_BITS;
    assign gs_rd = lat_rise && !sck_rise && cnt_r == CMD_BITS && cmd == CMD_GS_READ;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    property p_gs_write;
        gs_wr |=> gs_r == $past(shift_r) && shift_r[FBC_WIDTH-1:0] == $past(fbc_data_i);
    endproperty
    a_gs_write: assert property (p_gs_write) else $error("gs write lost");

    property p_cfg_write;
        lat_rise && !sck_rise && cnt_r != GS_BITS && cnt_r != CMD_BITS
            |=> fbc_load_o && common_word_o == $past(shift_r) ##1 !fbc_load_o;
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config pulse wrong");

    property p_sid_read;
        lat_rise && !sck_rise && cnt_r == CMD_BITS && cmd == CMD_SID_READ
            |=> shift_r == $past(status_info_data_i) && !err_clear_o;
    endproperty
    a_sid_read: assert property (p_sid_read) else $error("status not loaded");

    property p_gs_read;
        gs_rd |=> shift_r == $past(gs_r) && serial_out_pin_o == $past(gs_r[287]);
    endproperty
    a_gs_read: assert property (p_gs_read) else $error("gs read wrong");

    property p_shift_out;
        sck_rise |=> serial_out_pin_o == $past(shift_r[286]) && cnt_r != CNT_RESET;
    endproperty
    a_shift_out: assert property (p_shift_out) else $error("serial out wrong");

    property p_reset;
        @(posedge mclk_i) disable iff (1'b0)
            rst_i |=> gs_r == GS_RESET && !serial_out_pin_o && cnt_r == CNT_RESET;
    endproperty
    a_reset: assert property (p_reset) else $error("reset value wrong");

    property p_ch7;
        gs_wr |=> blue_group_output_o[7] == $past(shift_r[287:276])
            && red_group_output_o[7] == $past(shift_r[263:252]);
    endproperty
    a_ch7: assert property (p_ch7) else $error("channel 7 misplaced");

    property p_ch6;
        gs_wr |=> blue_group_output_o[6] == $past(shift_r[251:240])
            && red_group_output_o[6] == $past(shift_r[227:216]);
    endproperty
    a_ch6: assert property (p_ch6) else $error("channel 6 misplaced");

    property p_ch5;
        gs_wr |=> blue_group_output_o[5] == $past(shift_r[215:204])
            && red_group_output_o[5] == $past(shift_r[191:180]);
    endproperty
    a_ch5: assert property (p_ch5) else $error("channel 5 misplaced");

    property p_ch4;
        gs_wr |=> blue_group_output_o[4] == $past(shift_r[179:168])
            && red_group_output_o[4] == $past(shift_r[155:144]);
    endproperty
    a_ch4: assert property (p_ch4) else $error("channel 4 misplaced");

    property p_ch3;
        gs_wr |=> blue_group_output_o[3] == $past(shift_r[143:132])
            && red_group_output_o[3] == $past(shift_r[119:108]);
    endproperty
    a_ch3: assert property (p_ch3) else $error("channel 3 misplaced");

    property p_ch2;
        gs_wr |=> blue_group_output_o[2] == $past(shift_r[107:96])
            && red_group_output_o[2] == $past(shift_r[83:72]);
    endproperty
    a_ch2: assert property (p_ch2) else $error("channel 2 misplaced");

    property p_ch1;
        gs_wr |=> blue_group_output_o[1] == $past(shift_r[71:60])
            && red_group_output_o[1] == $past(shift_r[47:36]);
    endproperty
    a_ch1: assert property (p_ch1) else $error("channel 1 misplaced");

    property p_ch0;
        gs_wr |=> blue_group_output_o[0] == $past(shift_r[35:24])
            && red_group_output_o[0] == $past(shift_r[11:0]);
    endproperty
    a_ch0: assert property (p_ch0) else $error("channel 0 misplaced");

    property p_reserved;
        gs_rd |=> shift_r[275:264] == $past(gs_r[275:264])
            && $stable(blue_group_output_o) && $stable(red_group_output_o);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved slot lost");

    c_gs_write: cover property (gs_wr);
    c_gs_read: cover property (gs_rd);
    c_cfg_write: cover property (fbc_load_o);
    c_err_clear: cover property (err_clear_o);
endmodule
`default_nettype wire
